// File: design/adi_pkg.sv
// Package: configuration byte layout and mode encodings for drive init and mode select
package adi_pkg;
    // Configuration byte indices
    localparam logic [3:0] ADI_SIG0_IDX       = 4'h0;
    localparam logic [3:0] ADI_SIG1_IDX       = 4'h1;
    localparam logic [3:0] ADI_RST_OPT_IDX    = 4'h5;
    localparam logic [3:0] ADI_UDMA_CFG_IDX   = 4'h6;
    localparam logic [3:0] ADI_PIO_DMA_IDX    = 4'h7;
    // Signature values
    localparam logic [7:0] ADI_SIG0_VAL       = 8'h53;
    localparam logic [7:0] ADI_SIG1_VAL       = 8'h4b;
    // Field positions
    localparam int ADI_SRST_EN_BIT    = 1;
    localparam int ADI_SKIP_PIN_BIT   = 0;
    localparam int ADI_ATA_UDMA_BIT   = 7;
    localparam int ADI_ATAPI_UDMA_BIT = 6;
    localparam int ADI_UDMA4_BIT      = 4;
    localparam int ADI_UDMA3_BIT      = 3;
    localparam int ADI_UDMA2_BIT      = 2;
    localparam int ADI_MWDMA_BIT      = 2;
    localparam int ADI_PIO4_BIT       = 1;
    localparam int ADI_PIO3_BIT       = 0;
    // Reset values before a valid image is loaded
    localparam logic [7:0] ADI_RST_OPT_RST    = 8'h02;
    localparam logic [7:0] ADI_UDMA_CFG_RST   = 8'h00;
    localparam logic [7:0] ADI_PIO_DMA_RST    = 8'h00;
    // Hard reset pulse and software reset pulse, in ns, and derived cycles at 40 MHz
    localparam int ADI_CLK_PERIOD_NS  = 25;
    localparam int ADI_HRST_NS        = 25000;
    localparam int ADI_SRST_NS        = 5000;
    localparam int ADI_HRST_CYC       = (ADI_HRST_NS + ADI_CLK_PERIOD_NS - 1) / ADI_CLK_PERIOD_NS;
    localparam int ADI_SRST_CYC       = (ADI_SRST_NS + ADI_CLK_PERIOD_NS - 1) / ADI_CLK_PERIOD_NS;
    // Transfer protocol encoding
    typedef enum logic [1:0] {
        ADI_XFER_PIO   = 2'b00,
        ADI_XFER_MWDMA = 2'b01,
        ADI_XFER_UDMA  = 2'b10
    } adi_xfer_type;
    // Init sequencer states
    typedef enum logic [1:0] {
        ADI_ST_IDLE = 2'b00,
        ADI_ST_HRST = 2'b01,
        ADI_ST_SRST = 2'b10,
        ADI_ST_DONE = 2'b11
    } adi_state_type;
endpackage

// File: design/adi_init_mode_select.sv
// Drive reset sequencing and transfer mode selection from configuration bytes
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - SRST enable bit one issues software reset during drive init; zero skips it.
// - Skip bit one: hard reset pin only on chip reset; zero: every reset.
// - Byte 6 bit 7 with ATA drive UDMA support selects UDMA.
// - Byte 6 bit 6 with ATAPI drive UDMA support selects UDMA.
// - UDMA field bits 4, 3, 2 enable UDMA modes 4, 3, 2.
// - Run highest UDMA mode enabled and supported; only modes 2 to 4.
// - Byte 7 bit 2 with drive support selects multiword DMA.
// - Bit 1 enables PIO 4, bit 0 PIO 3; highest supported wins.
module adi_init_mode_select #(
    parameter int HRST_CYCLES = adi_pkg::ADI_HRST_CYC,
    parameter int SRST_CYCLES = adi_pkg::ADI_SRST_CYC
) (
    // Clock and reset
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst_n,
    // Configuration byte stream from the serial memory loader
    input  wire logic                 i_cfg_valid,
    input  wire logic [3:0]           i_cfg_addr,
    input  wire logic [7:0]           i_cfg_data,
    input  wire logic                 i_cfg_done,
    // Drive init request and drive capabilities
    input  wire logic                 i_init_req,
    input  wire logic                 i_drive_atapi,
    input  wire logic [6:0]           i_drive_udma_modes,
    input  wire logic                 i_drive_mwdma2,
    input  wire logic [1:0]           i_drive_pio_modes,
    // Drive reset controls
    output logic                      o_drive_hard_reset_n,
    output logic                      o_srst_req,
    output logic                      o_init_busy,
    // Selected transfer mode
    output adi_pkg::adi_xfer_type     o_xfer_type,
    output logic [2:0]                o_udma_mode,
    output logic [2:0]                o_pio_mode,
    output logic                      o_cfg_applied
);
    import adi_pkg::*;

    localparam int CW = 16;

    typedef struct packed {
        logic [7:0]    rst_opt;
        logic [7:0]    udma_cfg;
        logic [7:0]    pio_dma;
        logic          sig0_ok;
        logic          sig1_ok;
        logic          applied;
        logic          first;
        adi_state_type st;
        logic [CW-1:0] cnt;
        logic          hrst_n;
        logic          srst;
        logic          busy;
        adi_xfer_type  xfer;
        logic [2:0]    udma;
        logic [2:0]    pio;
    } adi_regs_type;

    adi_regs_type r_q;
    adi_regs_type r_d;
    logic         udma_ok;
    logic         do_hrst;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        r_d     = r_q;
        udma_ok = 1'b0;
        do_hrst = 1'b0;
        // Capture image bytes; option bytes are used as captured, and a bad signature at done restores their reset values
        if (i_cfg_valid) begin
            case (i_cfg_addr)
                ADI_SIG0_IDX:     r_d.sig0_ok  = (i_cfg_data == ADI_SIG0_VAL);
                ADI_SIG1_IDX:     r_d.sig1_ok  = (i_cfg_data == ADI_SIG1_VAL);
                ADI_RST_OPT_IDX:  r_d.rst_opt  = i_cfg_data;
                ADI_UDMA_CFG_IDX: r_d.udma_cfg = i_cfg_data;
                ADI_PIO_DMA_IDX:  r_d.pio_dma  = i_cfg_data;
                default:          r_d.applied  = r_q.applied;
            endcase
        end
        if (i_cfg_done) begin
            r_d.applied = r_q.sig0_ok && r_q.sig1_ok;
            if (!(r_q.sig0_ok && r_q.sig1_ok)) begin
                r_d.rst_opt  = ADI_RST_OPT_RST;
                r_d.udma_cfg = ADI_UDMA_CFG_RST;
                r_d.pio_dma  = ADI_PIO_DMA_RST;
            end
        end
        // Hard reset on chip reset always; otherwise only when not skipped
        do_hrst = r_q.first || !r_q.rst_opt[ADI_SKIP_PIN_BIT];
        // Reset sequencer; relies on the writer enabling one method
        case (r_q.st)
            ADI_ST_IDLE: begin
                if (i_init_req) begin
                    r_d.busy = 1'b1;
                    r_d.cnt  = '0;
                    if (do_hrst) begin
                        r_d.st     = ADI_ST_HRST;
                        r_d.hrst_n = 1'b0;
                    end else if (r_q.rst_opt[ADI_SRST_EN_BIT]) begin
                        r_d.st   = ADI_ST_SRST;
                        r_d.srst = 1'b1;
                    end else begin
                        r_d.st = ADI_ST_DONE;
                    end
                end
            end
            ADI_ST_HRST: begin
                r_d.cnt = r_q.cnt + 1'b1;
                if (r_q.cnt == CW'(HRST_CYCLES - 1)) begin
                    r_d.hrst_n = 1'b1;
                    r_d.first  = 1'b0;
                    r_d.cnt    = '0;
                    if (r_q.rst_opt[ADI_SRST_EN_BIT]) begin
                        r_d.st   = ADI_ST_SRST;
                        r_d.srst = 1'b1;
                    end else begin
                        r_d.st = ADI_ST_DONE;
                    end
                end
            end
            ADI_ST_SRST: begin
                r_d.cnt = r_q.cnt + 1'b1;
                if (r_q.cnt == CW'(SRST_CYCLES - 1)) begin
                    r_d.srst = 1'b0;
                    r_d.st   = ADI_ST_DONE;
                end
            end
            ADI_ST_DONE: begin
                r_d.busy = 1'b0;
                r_d.st   = ADI_ST_IDLE;
            end
            default: r_d.st = ADI_ST_IDLE;
        endcase
        // UDMA gated per drive class
        udma_ok = i_drive_atapi ? r_q.udma_cfg[ADI_ATAPI_UDMA_BIT]
                                : r_q.udma_cfg[ADI_ATA_UDMA_BIT];
        // Highest enabled and supported UDMA mode, 2..4 only
        r_d.udma = 3'd0;
        if (r_q.udma_cfg[ADI_UDMA4_BIT] && i_drive_udma_modes[4]) begin
            r_d.udma = 3'd4;
        end else if (r_q.udma_cfg[ADI_UDMA3_BIT] && i_drive_udma_modes[3]) begin
            r_d.udma = 3'd3;
        end else if (r_q.udma_cfg[ADI_UDMA2_BIT] && i_drive_udma_modes[2]) begin
            r_d.udma = 3'd2;
        end
        // Highest PIO; mode 0 needs no enable
        r_d.pio = 3'd0;
        if (r_q.pio_dma[ADI_PIO4_BIT] && i_drive_pio_modes[1]) begin
            r_d.pio = 3'd4;
        end else if (r_q.pio_dma[ADI_PIO3_BIT] && i_drive_pio_modes[0]) begin
            r_d.pio = 3'd3;
        end
        // Protocol preference UDMA, then multiword DMA, then PIO
        if (udma_ok && r_d.udma != 3'd0) begin
            r_d.xfer = ADI_XFER_UDMA;
        end else if (r_q.pio_dma[ADI_MWDMA_BIT] && i_drive_mwdma2) begin
            r_d.xfer = ADI_XFER_MWDMA;
        end else begin
            r_d.xfer = ADI_XFER_PIO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; first marks the chip reset init
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            r_q          <= '0;
            r_q.rst_opt  <= ADI_RST_OPT_RST;
            r_q.first    <= 1'b1;
            r_q.hrst_n   <= 1'b1;
            r_q.st       <= ADI_ST_IDLE;
            r_q.xfer     <= ADI_XFER_PIO;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs straight from flops
    assign o_drive_hard_reset_n = r_q.hrst_n;
    assign o_srst_req           = r_q.srst;
    assign o_init_busy          = r_q.busy;
    assign o_xfer_type          = r_q.xfer;
    assign o_udma_mode          = r_q.udma;
    assign o_pio_mode           = r_q.pio;
    assign o_cfg_applied        = r_q.applied;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_hrst_start;
        $fell(o_drive_hard_reset_n);
    endsequence
    // Pulse end; the SRST choice was made one edge before the pin rose
    sequence s_hrst_end;
        $rose(o_drive_hard_reset_n) ##0 $past(r_q.rst_opt[ADI_SRST_EN_BIT]);
    endsequence

    // Checked at the pulse end, so the long pulse needs no long delay
    a_srst_after_hrst: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        s_hrst_end |-> o_srst_req)
        else $error("Software reset did not follow hard reset");
    a_no_srst_disabled: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(o_srst_req) |-> $past(r_q.rst_opt[ADI_SRST_EN_BIT]))
        else $error("Software reset issued while disabled");
    a_hrst_skip: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $fell(o_drive_hard_reset_n) |-> ($past(r_q.first) || !$past(r_q.rst_opt[0])))
        else $error("Hard reset asserted while skipped");
    a_hrst_width: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        s_hrst_start |-> !o_drive_hard_reset_n [*8])
        else $error("Hard reset pulse too short");
    a_udma_class: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_xfer_type == ADI_XFER_UDMA |-> $past(i_drive_atapi ? r_q.udma_cfg[6] : r_q.udma_cfg[7]))
        else $error("UDMA chosen while disabled for drive class");
    a_udma_range: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_udma_mode != 3'd0 |-> (o_udma_mode >= 3'd2 && o_udma_mode <= 3'd4))
        else $error("Unsupported UDMA mode selected");
    a_udma4_pick: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (r_q.udma_cfg[4] && i_drive_udma_modes[4]) |=> o_udma_mode == 3'd4)
        else $error("UDMA mode 4 not selected");
    a_pio_pick: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (r_q.pio_dma[1] && i_drive_pio_modes[1]) |=> o_pio_mode == 3'd4)
        else $error("PIO mode 4 not selected");
    a_pio_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (!r_q.pio_dma[1] && !r_q.pio_dma[0]) |=> o_pio_mode == 3'd0)
        else $error("PIO mode other than 0 without enable");
    a_mwdma_pref: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (r_q.pio_dma[2] && i_drive_mwdma2) |=> o_xfer_type != ADI_XFER_PIO)
        else $error("PIO chosen over multiword DMA");
    a_sig_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(o_cfg_applied) |-> $past(r_q.sig0_ok && r_q.sig1_ok))
        else $error("Configuration applied without signature");
endmodule

`default_nettype wire

// File: bench/adi_drive_model.sv
// Drive-side model that counts the reset pulses seen on the drive interface
`timescale 1ns/10ps
`default_nettype none
module adi_drive_model (
    // Clock and reset controls from the bridge
    input  wire logic        i_ref_clk,
    input  wire logic        i_drive_hard_reset_n,
    input  wire logic        i_srst_req,
    // Pulse counts and in-force cycle counts
    output logic [31:0]      o_hrst_cnt,
    output logic [31:0]      o_hrst_cyc,
    output logic [31:0]      o_srst_cnt,
    output logic [31:0]      o_srst_cyc
);
    logic        hr_q   = 1'b1;
    logic        sr_q   = 1'b0;
    // Counters start at zero so the bench only ever looks at deltas
    logic [31:0] hcnt_q = 32'h0;
    logic [31:0] hcyc_q = 32'h0;
    logic [31:0] scnt_q = 32'h0;
    logic [31:0] scyc_q = 32'h0;
    // A pulse counts once at its leading edge, and its width cycle by cycle
    always @(posedge i_ref_clk) begin
        hr_q <= i_drive_hard_reset_n;
        sr_q <= i_srst_req;
        if (!i_drive_hard_reset_n && hr_q) hcnt_q <= hcnt_q + 1;
        if (!i_drive_hard_reset_n) hcyc_q <= hcyc_q + 1;
        if (i_srst_req && !sr_q) scnt_q <= scnt_q + 1;
        if (i_srst_req) scyc_q <= scyc_q + 1;
    end
    // One driver per output
    assign o_hrst_cnt = hcnt_q;
    assign o_hrst_cyc = hcyc_q;
    assign o_srst_cnt = scnt_q;
    assign o_srst_cyc = scyc_q;
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for drive reset sequencing and mode selection
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import adi_pkg::*;
    logic i_ref_clk = 1'b0, i_rst_n = 1'b0, cfg_valid = 1'b0, cfg_done = 1'b0, init_req = 1'b0;
    logic [3:0] cfg_addr = 4'h0;
    logic [7:0] cfg_data = 8'h00;
    logic atapi = 1'b0, mw = 1'b0, hrst_n, srst, busy, applied;
    logic [6:0] udma = 7'h00;
    logic [1:0] pio = 2'h0;
    adi_xfer_type xfer;
    logic [2:0] umode, pmode;
    logic [31:0] hc, hw, sc, sw;
    int fail_count = 0, cmp_count = 0;
    always #12.5 i_ref_clk = ~i_ref_clk;
    adi_init_mode_select uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cfg_valid(cfg_valid),
        .i_cfg_addr(cfg_addr), .i_cfg_data(cfg_data), .i_cfg_done(cfg_done),
        .i_init_req(init_req), .i_drive_atapi(atapi), .i_drive_udma_modes(udma),
        .i_drive_mwdma2(mw), .i_drive_pio_modes(pio), .o_drive_hard_reset_n(hrst_n),
        .o_srst_req(srst), .o_init_busy(busy), .o_xfer_type(xfer), .o_udma_mode(umode),
        .o_pio_mode(pmode), .o_cfg_applied(applied));
    adi_drive_model drv (.i_ref_clk(i_ref_clk), .i_drive_hard_reset_n(hrst_n),
        .i_srst_req(srst), .o_hrst_cnt(hc), .o_hrst_cyc(hw), .o_srst_cnt(sc), .o_srst_cyc(sw));
    ////////////////////////////////////////////////////////////////////////////////
    // Inputs always move 2 ns after the edge, clear of sampling
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #2;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Valid stays high across the bytes, so no double drive in one step
    task automatic load(input logic [7:0] s1, input logic [7:0] b5, input logic [7:0] b6,
                        input logic [7:0] b7);
        logic [3:0] a[5] = '{ADI_SIG0_IDX, ADI_SIG1_IDX, ADI_RST_OPT_IDX,
                             ADI_UDMA_CFG_IDX, ADI_PIO_DMA_IDX};
        logic [7:0] d[5] = '{ADI_SIG0_VAL, s1, b5, b6, b7};
        cfg_valid = 1'b1;
        for (int i = 0; i < 5; i++) begin
            cfg_addr = a[i];
            cfg_data = d[i];
            tick(1);
        end
        cfg_valid = 1'b0;
        cfg_done = 1'b1;
        tick(1);
        cfg_done = 1'b0;
        tick(2);
        chk(applied, s1 == ADI_SIG1_VAL);
    endtask
    // Second request lands mid-sequence and must be ignored
    task automatic init(input logic h, input logic s);
        logic [31:0] h0, w0, s0, v0;
        int n;
        h0 = hc;
        w0 = hw;
        s0 = sc;
        v0 = sw;
        init_req = 1'b1;
        tick(1);
        init_req = 1'b0;
        tick(4);
        chk(busy, 1'b1);
        init_req = 1'b1;
        tick(1);
        init_req = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            tick(1);
            n++;
        end
        tick(3);
        chk(busy, 1'b0);
        chk(hc - h0, h);
        chk(hw - w0, h ? ADI_HRST_CYC : 0);
        chk(sc - s0, s);
        chk(sw - v0, s ? ADI_SRST_CYC : 0);
        $display("test init done");
    endtask
    task automatic mode(input logic a, input logic [6:0] u, input logic m, input logic [1:0] p,
                        input adi_xfer_type et, input logic [2:0] eu, input logic [2:0] ep);
        atapi = a;
        udma = u;
        mw = m;
        pio = p;
        tick(2);
        chk(xfer, et);
        chk(umode, eu);
        chk(pmode, ep);
        $display("test mode done");
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; every load keeps a reset method and reserved bits clear
    initial begin
        tick(10);
        i_rst_n = 1'b1;
        // Skip bit set before the first init: chip reset still pulses the pin
        load(ADI_SIG1_VAL, 8'h03, 8'h94, 8'h07);
        init(1'b1, 1'b1);
        init(1'b0, 1'b1);
        mode(1'b0, 7'h7f, 1'b1, 2'h3, ADI_XFER_UDMA, 3'h4, 3'h4);
        mode(1'b0, 7'h0c, 1'b1, 2'h3, ADI_XFER_UDMA, 3'h2, 3'h4);
        mode(1'b0, 7'h03, 1'b1, 2'h1, ADI_XFER_MWDMA, 3'h0, 3'h3);
        mode(1'b1, 7'h1c, 1'b1, 2'h2, ADI_XFER_MWDMA, 3'h4, 3'h4);
        mode(1'b0, 7'h00, 1'b0, 2'h0, ADI_XFER_PIO, 3'h0, 3'h0);
        load(ADI_SIG1_VAL, 8'h00, 8'h5c, 8'h01);
        init(1'b1, 1'b0);
        mode(1'b1, 7'h10, 1'b1, 2'h3, ADI_XFER_UDMA, 3'h4, 3'h3);
        mode(1'b0, 7'h7f, 1'b1, 2'h3, ADI_XFER_PIO, 3'h4, 3'h3);
        load(8'h4a, 8'h03, 8'hd4, 8'h07);
        init(1'b1, 1'b1);
        mode(1'b0, 7'h7f, 1'b1, 2'h3, ADI_XFER_PIO, 3'h0, 3'h0);
        give_verdict();
    end
    // Run is about 3700 cycles; over ten times that means a hang
    initial begin
        repeat (40000) @(posedge i_ref_clk);
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
